// [verilog/scr_map.svh]
// constants of the sensor control register bank: offsets, fields, masks, resets
// assumes command bytes and data bytes arrive already framed by the serial front end
// Operation
// RQ1 - offset and all thresholds live at addresses 0x00 through 0x0A
// RQ2 - interrupt enable, routing and source registers occupy 0x0B through 0x0D
// RQ3 - a register switches output compensation; address conflict, held at 0x0F here
// RQ4 - host should program control registers before starting conversions
// RQ5 - bytes 0x00 low and 0x01 high form the 16-bit altitude offset
// RQ6 - altitude offset is signed centimetres; host loads it before using altitude
// RQ7 - three 16-bit pressure thresholds at 0x02-0x07, temperature thresholds 0x08-0x0A
// RQ8 - registers 0x00 through 0x0E reset to zero
// RQ9 - enable register: bits 7:6 reserved, bits 5:0 enable six sources
// RQ10 - routing register: bit 7 reserved, bit 6 mode select, 5:0 route
// RQ11 - source register: bit 7 threshold error, bit 6 ready, 5:0 flags
// RQ12 - direction register: bits 3:0 crossing and window directions, 6:4 reserved
// RQ13 - compensation register: bit 7 enable, resets to 0x80
// RQ14 - command top bits 11 write with data byte, 10 read; low six address
// RQ15 - mode select 0 means pressure, 1 means altitude
// RQ16 - compensation enable 1 gives compensated results, 0 gives raw data
// RQ17 - enabled source with routing bit 0 sets flag but not the pin
// RQ18 - reserved bits ignore writes, read zero; unmapped addresses read zero
// RQ19 - writes to the source flag register are ignored
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

`define SCR_ADDR_ALT_LO 6'h00
`define SCR_ADDR_ALT_HI 6'h01
`define SCR_ADDR_PUP_LO 6'h02
`define SCR_ADDR_PUP_HI 6'h03
`define SCR_ADDR_PMID_LO 6'h04
`define SCR_ADDR_PMID_HI 6'h05
`define SCR_ADDR_PLOW_LO 6'h06
`define SCR_ADDR_PLOW_HI 6'h07
`define SCR_ADDR_TUP 6'h08
`define SCR_ADDR_TMID 6'h09
`define SCR_ADDR_TLOW 6'h0a
`define SCR_ADDR_INT_EN 6'h0b
`define SCR_ADDR_INT_ROUTE 6'h0c
`define SCR_ADDR_INTERRUPT_SOURCE_FLAGS 6'h0d
`define SCR_ADDR_DIR 6'h0e
`define SCR_ADDR_COMP 6'h0f

`define SCR_CMD_WRITE 2'h3
`define SCR_CMD_READ 2'h2

`define SCR_MASK_FULL 8'hff
`define SCR_MASK_INT_EN 8'h3f
`define SCR_MASK_INT_ROUTE 8'h7f
`define SCR_MASK_COMP 8'h80

`define SCR_RESET_ZERO 8'h00
`define SCR_RESET_COMP 8'h80

`define SCR_BIT_MODE 6
`define SCR_BIT_COMP 7
`define SCR_BIT_THRESHOLD_SETTING_ERROR 7
`define SCR_BIT_DEV_RDY 6

`endif

// [verilog/scr_pkg.sv]
// types of the sensor control register bank
// assumes nothing beyond the map header
package scr_pkg;
  typedef enum logic [0:0] {
    SCR_IDLE,
    SCR_WAIT_DATA
  } scr_state_t;
endpackage : scr_pkg

// [verilog/scr_reg_bank.sv]
// control register bank: offset, thresholds, interrupt control, compensation
// assumes a serial front end hands over command bytes, data bytes and read strobes
`include "scr_map.svh"

module scr_reg_bank
  import scr_pkg::*;
#(
  parameter int NUM_SRC = 6
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  input wire logic read_strobe,
  output logic [7:0] read_data,
  output logic read_valid,
  input wire logic [NUM_SRC-1:0] event_set,
  input wire logic flags_clear,
  input wire logic [3:0] direction_in,
  input wire logic threshold_setting_error,
  input wire logic device_ready,
  output logic [15:0] altitude_offset,
  output logic [15:0] press_upper_threshold,
  output logic [15:0] press_middle_threshold,
  output logic [15:0] press_lower_threshold,
  output logic [7:0] temp_upper_threshold,
  output logic [7:0] temp_middle_threshold,
  output logic [7:0] temp_lower_threshold,
  output logic pressure_or_altitude_select,
  output logic compensation_on,
  output logic [NUM_SRC-1:0] interrupt_source_flags,
  output logic interrupt_output_pin
);

  localparam int NUM_RW = 13;

  scr_state_t state;
  logic [5:0] wr_addr;
  logic [5:0] rd_addr;
  logic [7:0] regs [0:NUM_RW-1];
  logic [7:0] comp_reg;
  logic [3:0] direction;
  logic wr_fire;
  logic [7:0] next_read;

  // command decoder: write waits for its data byte, read latches the address
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= SCR_IDLE;
      wr_addr <= 6'h00;
      rd_addr <= 6'h00;
    end
    else if (cmd_valid)
    begin
      state <= SCR_IDLE;
      case (cmd_byte[7:6])
        `SCR_CMD_WRITE:
        begin
          state <= SCR_WAIT_DATA; // see RQ14
          wr_addr <= cmd_byte[5:0];
        end
        `SCR_CMD_READ:
        begin
          rd_addr <= cmd_byte[5:0]; // see RQ14
        end
        default:
        begin
          state <= SCR_IDLE;
        end
      endcase
    end
    else
    begin
      case (state)
        SCR_WAIT_DATA:
        begin
          if (data_valid)
          begin
            state <= SCR_IDLE;
          end
        end
        default:
        begin
          state <= SCR_IDLE;
        end
      endcase
    end
  end

  assign wr_fire = (state == SCR_WAIT_DATA) && data_valid && !cmd_valid;

  // writable bytes 0x00-0x0c, reserved bits masked off on write
  genvar gi;
  generate
    for (gi = 0; gi < NUM_RW; gi++)
    begin : g_reg
      localparam logic [7:0] WMASK = (gi == 11) ? `SCR_MASK_INT_EN :
                                     (gi == 12) ? `SCR_MASK_INT_ROUTE : `SCR_MASK_FULL;
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          regs[gi] <= `SCR_RESET_ZERO; // see RQ8
        end
        else if (wr_fire && wr_addr == 6'(gi))
        begin
          regs[gi] <= data_byte & WMASK; // see RQ1, RQ2, RQ9, RQ10, RQ18
        end
      end
    end
  endgenerate

  // compensation control, on after reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      comp_reg <= `SCR_RESET_COMP; // see RQ13
    end
    else if (wr_fire && wr_addr == `SCR_ADDR_COMP)
    begin
      comp_reg <= data_byte & `SCR_MASK_COMP; // see RQ3, RQ18
    end
  end

  // sticky flags: enabled events set, new conversion (flags_clear) clears, read commands do not; set wins
  generate
    for (gi = 0; gi < NUM_SRC; gi++)
    begin : g_flag
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          interrupt_source_flags[gi] <= 1'b0;
        end
        else if (event_set[gi] && regs[11][gi])
        begin
          interrupt_source_flags[gi] <= 1'b1; // see RQ17
        end
        else if (flags_clear)
        begin
          interrupt_source_flags[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // direction bits follow the event logic when a crossing or window event lands
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_dir
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          direction[gi] <= 1'b0; // see RQ8
        end
        else if (event_set[gi])
        begin
          direction[gi] <= direction_in[gi]; // see RQ12
        end
        else if (flags_clear)
        begin
          direction[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // read mux; source register ignores writes and shows live status
  always_comb
  begin
    next_read = 8'h00; // see RQ18
    if (rd_addr < 6'(NUM_RW))
    begin
      next_read = regs[rd_addr[3:0]];
    end
    else if (rd_addr == `SCR_ADDR_INTERRUPT_SOURCE_FLAGS)
    begin
      next_read = {threshold_setting_error, device_ready, interrupt_source_flags}; // see RQ11, RQ19
    end
    else if (rd_addr == `SCR_ADDR_DIR)
    begin
      next_read = {4'h0, direction}; // see RQ12
    end
    else if (rd_addr == `SCR_ADDR_COMP)
    begin
      next_read = comp_reg;
    end
  end

  // read answer registered one cycle after the strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      read_data <= 8'h00;
      read_valid <= 1'b0;
    end
    else
    begin
      read_valid <= read_strobe;
      if (read_strobe)
      begin
        read_data <= next_read;
      end
    end
  end

  // values handed to the conversion and event logic
  assign altitude_offset = {regs[1], regs[0]}; // see RQ5, RQ6
  assign press_upper_threshold = {regs[3], regs[2]}; // see RQ7
  assign press_middle_threshold = {regs[5], regs[4]}; // see RQ7
  assign press_lower_threshold = {regs[7], regs[6]}; // see RQ7
  assign temp_upper_threshold = regs[8];
  assign temp_middle_threshold = regs[9];
  assign temp_lower_threshold = regs[10];
  assign pressure_or_altitude_select = regs[12][`SCR_BIT_MODE]; // see RQ15
  assign compensation_on = comp_reg[`SCR_BIT_COMP]; // see RQ16

  // pin shows only flags whose routing bit is set
  assign interrupt_output_pin = |(interrupt_source_flags & regs[12][NUM_SRC-1:0]); // see RQ17

endmodule : scr_reg_bank

// [dv/scr_host.sv]
// host model: sends register commands, data bytes and read frames
// assumes the bank samples every strobe at the rising clock edge
`include "scr_map.svh"
module scr_host (
  input wire logic clk,
  output logic cmd_valid = 1'h0,
  output logic [7:0] cmd_byte = 8'h00,
  output logic data_valid = 1'h0,
  output logic [7:0] data_byte = 8'h00,
  output logic read_strobe = 1'h0,
  input wire logic [7:0] read_data,
  input wire logic read_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // command byte: top bits pick the access, low six the address
  task cmd(input logic [1:0] op, input logic [5:0] a);
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd_byte <= {op, a};
    @(posedge clk);
    cmd_valid <= 1'h0;
    cmd_byte <= ~cmd_byte;
  endtask : cmd
  // one data byte after a write command
  task dat(input logic [7:0] d);
    @(posedge clk);
    data_valid <= 1'h1;
    data_byte <= d;
    @(posedge clk);
    data_valid <= 1'h0;
    data_byte <= ~d;
  endtask : dat
  // read command, then a separate read frame
  task rd(input logic [5:0] a, output logic [7:0] d, output logic v);
    cmd(`SCR_CMD_READ, a);
    @(posedge clk);
    read_strobe <= 1'h1;
    @(posedge clk);
    read_strobe <= 1'h0;
    #1;
    d = read_data;
    v = read_valid;
  endtask : rd
endmodule : scr_host

// [dv/scr_checker.sv]
// checker: timing relations at the register bank ports
// assumes one clock domain with an async active-high reset
module scr_checker #(
  parameter int NUM_SRC = 6
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic data_valid,
  input wire logic read_strobe,
  input wire logic read_valid,
  input wire logic [7:0] read_data,
  input wire logic [NUM_SRC-1:0] event_set,
  input wire logic flags_clear,
  input wire logic [NUM_SRC-1:0] interrupt_source_flags,
  input wire logic interrupt_output_pin,
  input wire logic [15:0] altitude_offset,
  input wire logic compensation_on,
  input wire logic pressure_or_altitude_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_answer; read_strobe |=> read_valid; endproperty
  a_answer: assert property (p_answer) else $error("read answer missing");
  property p_once; !read_strobe |=> !read_valid; endproperty
  a_once: assert property (p_once) else $error("stray read answer");
  property p_hold; !read_strobe |=> $stable(read_data); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_pin; interrupt_output_pin |-> (|interrupt_source_flags); endproperty
  a_pin: assert property (p_pin) else $error("pin without flag");
  property p_clear; flags_clear && event_set == 0 |=> interrupt_source_flags == 0; endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");
  property p_sticky; !flags_clear |=> ($past(interrupt_source_flags) & ~interrupt_source_flags) == 0; endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_cause; event_set == 0 |=> (interrupt_source_flags & ~$past(interrupt_source_flags)) == 0; endproperty
  a_cause: assert property (p_cause) else $error("flag without event");
  property p_cfg;
    !data_valid |=> $stable(altitude_offset) && $stable(compensation_on) && $stable(pressure_or_altitude_select);
  endproperty
  a_cfg: assert property (p_cfg) else $error("setting moved without write");
  c_read: cover property (read_valid);
  c_pin: cover property (interrupt_output_pin);
  c_clear: cover property (flags_clear && |interrupt_source_flags);
endmodule : scr_checker
bind scr_reg_bank scr_checker #(.NUM_SRC(NUM_SRC)) scr_checker_inst (.*);

// [dv/tb_top.sv]
// bench: random register traffic and events against an array model
// assumes host model and checker are compiled before it
`include "scr_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cmd_valid, data_valid, read_strobe, read_valid, interrupt_output_pin, v, c;
  logic pressure_or_altitude_select, compensation_on;
  logic flags_clear = 1'h0;
  logic threshold_setting_error = 1'h0;
  logic device_ready = 1'h0;
  logic [7:0] cmd_byte, data_byte, read_data, rv;
  logic [7:0] temp_upper_threshold, temp_middle_threshold, temp_lower_threshold;
  logic [15:0] altitude_offset, press_upper_threshold, press_middle_threshold, press_lower_threshold;
  logic [5:0] interrupt_source_flags, e;
  logic [5:0] event_set = 6'h00;
  logic [3:0] direction_in = 4'h0;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int m[64];
  scr_reg_bank scr_reg_bank_inst (.*);
  scr_host scr_host_inst (.*);
  always #50 clk = ~clk;
  task chk(input string n, input logic [15:0] x, input logic [15:0] g);
    checked++;
    if (g !== x)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  // expected read value: source register shows live status bits
  function automatic logic [7:0] ex(input int a);
    if (a == 13)
      return {threshold_setting_error, device_ready, 6'(m[13])};
    return 8'(m[a]);
  endfunction : ex
  function automatic logic [15:0] pr(input int a);
    return {8'(m[a + 1]), 8'(m[a])};
  endfunction : pr
  // write through the host and mirror into the model with reserved bits dropped
  task wm(input int a, input logic [7:0] d);
    logic [7:0] k;
    k = a < 11 ? 8'hff : a == 11 ? 8'h3f : a == 12 ? 8'h7f : a == 15 ? 8'h80 : 8'h00;
    if (k != 8'h00)
      m[a] = d & k;
    scr_host_inst.cmd(`SCR_CMD_WRITE, 6'(a));
    scr_host_inst.dat(d);
  endtask : wm
  task ra;
    for (int a = 0; a < 64; a++)
    begin
      scr_host_inst.rd(6'(a), rv, v);
      chk("read_valid", 16'h1, 16'(v));
      chk("read_data", 16'(ex(a)), 16'(rv));
    end
  endtask : ra
  // cut a hung run short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      err_total++;
      results();
    end
  end
  initial
  begin
    void'($urandom(32'hef30db72));
    m[15] = 128;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    ra();
    $display("test reset done");
    for (int a = 0; a < 64; a++)
      wm(a, 8'($urandom));
    ra();
    #1;
    chk("altitude", pr(0), altitude_offset);
    chk("p_up", pr(2), press_upper_threshold);
    chk("p_mid", pr(4), press_middle_threshold);
    chk("p_low", pr(6), press_lower_threshold);
    chk("t_th", {8'(m[8]), 8'(m[9])}, {temp_upper_threshold, temp_middle_threshold});
    chk("t_low", 16'(m[10]), 16'(temp_lower_threshold));
    chk("mode", 16'(m[12][6]), 16'(pressure_or_altitude_select));
    chk("comp", 16'(m[15][7]), 16'(compensation_on));
    $display("test map done");
    scr_host_inst.cmd(`SCR_CMD_WRITE, 6'h02);
    scr_host_inst.rd(6'h02, rv, v);
    scr_host_inst.dat(8'(~m[2]));
    #1;
    chk("abort", 16'(m[2]), 16'(press_upper_threshold[7:0]));
    scr_host_inst.cmd(`SCR_CMD_WRITE, 6'h02);
    scr_host_inst.cmd(2'h0, 6'h02);
    scr_host_inst.dat(8'(~m[2]));
    #1;
    chk("bad_code", 16'(m[2]), 16'(press_upper_threshold[7:0]));
    $display("test abort done");
    for (int i = 0; i < 24; i++)
    begin
      if (i == 12)
        wm(11, 8'($urandom));
      c = (i % 5 == 4);
      e = 6'($urandom);
      @(posedge clk);
      event_set <= e;
      flags_clear <= c;
      direction_in <= 4'($urandom);
      threshold_setting_error <= 1'($urandom);
      device_ready <= 1'($urandom);
      @(posedge clk);
      event_set <= 6'h00;
      flags_clear <= 1'h0;
      m[13] = c ? (e & m[11]) : m[13] | (e & m[11]);
      m[14] = c ? (direction_in & e[3:0]) : (m[14] & ~e[3:0]) | (direction_in & e[3:0]);
      #1;
      chk("flags", 16'(m[13]), 16'(interrupt_source_flags));
      chk("pin", 16'(|(m[13] & m[12] & 63)), 16'(interrupt_output_pin));
      scr_host_inst.rd(6'h0d, rv, v);
      chk("source", 16'(ex(13)), 16'(rv));
      scr_host_inst.rd(6'h0e, rv, v);
      chk("direction", 16'(m[14]), 16'(rv));
    end
    $display("test events done");
    results();
  end
endmodule : tb_top
